// >>> misc_ctrl_pkg.sv
// Shared constants and types for the miscellaneous control register group.
package misc_ctrl_pkg;
    localparam int ADDR_BITS = 12;
    localparam int GPIO_LINES = 3;
    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] IDX_DIR = 8'h3A;
    localparam logic [7:0] IDX_IO = 8'h3B;
    localparam logic [7:0] IDX_SW = 8'h3C;
    localparam logic [7:0] IDX_AUX1 = 8'h3D;
    localparam logic [7:0] IDX_AUX2 = 8'h3E;
    localparam logic [7:0] IDX_AUX3 = 8'h3F;
    localparam logic [7:0] IDX_PINMODE = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    // Values after reset.
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_IO = 8'h00;
    localparam logic [7:0] RST_SW = 8'h00;
    localparam logic [7:0] RST_AUX1 = 8'h00;
    localparam logic [7:0] RST_AUX2 = 8'h40;
    localparam logic [7:0] RST_AUX3 = 8'h00;
    localparam logic [7:0] RST_PINMODE = 8'h00;
    // Writable bits; all others are fixed zero.
    localparam logic [7:0] MASK_DIR = 8'h07;
    localparam logic [7:0] MASK_IO = 8'h07;
    localparam logic [7:0] MASK_SW = 8'h7F;
    localparam logic [7:0] MASK_AUX1 = 8'h27;
    localparam logic [7:0] MASK_AUX2 = 8'h68;
    localparam logic [7:0] MASK_AUX3 = 8'h40;
    localparam logic [7:0] MASK_PINMODE = 8'h01;
    // Field positions.
    localparam int SW_CODEC = 6;
    localparam int SW_LOOP = 5;
    localparam int SW_PXC = 4;
    localparam int SW_B2 = 2;
    localparam int SW_B1 = 0;
    localparam int AUX1_SOFT_RESET_HOLD = 5;
    localparam int AUX1_PD = 2;
    localparam int AUX1_OPS = 0;
    localparam int AUX2_SRC = 6;
    localparam int AUX2_LC = 5;
    localparam int AUX2_SPU = 3;
    localparam int AUX3_POL = 6;
    localparam int PIN_IRQ0 = 0;
    localparam int SHARED_LINE = 2;
    // Timing.
    localparam int CLK_NS = 40;
    localparam int SOFT_RESET_HOLD_HOLD_NS = 1000000;
    localparam int SOFT_RESET_HOLD_HOLD_CYC = (SOFT_RESET_HOLD_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int PHASE1_NS = 260;
    localparam int PHASE2_NS = 520;
    localparam int PHASE3_NS = 1040;
    localparam int PHASE1_CYC = (PHASE1_NS + CLK_NS - 1) / CLK_NS;
    localparam int PHASE2_CYC = (PHASE2_NS + CLK_NS - 1) / CLK_NS;
    localparam int PHASE3_CYC = (PHASE3_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] IDLE_OCTET = 8'hFF;

    typedef enum logic [1:0] {route_l2_l1, route_l1_pcm, route_pcm_l2} route_sel_t;
    typedef enum logic {pwr_awake, pwr_asleep} pwr_state_t;
    typedef struct packed {
        logic [7:0] l1;
        logic [7:0] l2;
        logic [7:0] pcm;
    } b_octets_t;
endpackage

// >>> b_channel_router.sv
// One B channel switch point joining layer 1/GCI, layer 2 and a PCM port.
`timescale 1ns/100ps
`default_nettype none
module b_channel_router (
    input wire logic aclk,
    input wire logic rst_n,
    input wire logic [1:0] sel,
    input var misc_ctrl_pkg::b_octets_t rx,
    output misc_ctrl_pkg::b_octets_t tx
);
    // Each octet arriving from one side is passed to the side the code pairs it with.
    // The unpaired side sends idle octets.
    always_ff @(posedge aclk) begin
        if (!rst_n) begin
            tx <= '{default: misc_ctrl_pkg::IDLE_OCTET};
        end else begin
            unique case (sel)
                misc_ctrl_pkg::route_l2_l1: begin
                    tx <= '{l1: rx.l2, l2: rx.l1, pcm: misc_ctrl_pkg::IDLE_OCTET};
                end
                misc_ctrl_pkg::route_l1_pcm: begin
                    tx <= '{l1: rx.pcm, l2: misc_ctrl_pkg::IDLE_OCTET, pcm: rx.l1};
                end
                misc_ctrl_pkg::route_pcm_l2: begin
                    tx <= '{l1: misc_ctrl_pkg::IDLE_OCTET, l2: rx.pcm, pcm: rx.l2};
                end
                default: begin
                    tx <= '{default: misc_ctrl_pkg::IDLE_OCTET};
                end
            endcase
        end
    end

    property p_route_code;
        @(posedge aclk) disable iff (!rst_n)
        (sel == 2'h0) |=> (tx.l1 == $past(rx.l2)) && (tx.l2 == $past(rx.l1));
    endproperty
    a_route_code: assert property (p_route_code) else $error("layer 2 to layer 1 pairing broken"); // RULE_07 RULE_08
endmodule
`default_nettype wire

// >>> misc_control_registers.sv
// Miscellaneous control registers: I/O lines, B channel switching, reset, power, pins.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE_01 - Reading an I/O data bit returns the present pin level.
// RULE_02 - Written I/O data drives its pin only while the direction bit is 1.
// RULE_03 - Software clears the shared pin mode bit before using that pin as I/O.
// RULE_04 - Codec bus select: 1 puts codec traffic on PCM, 0 on GCI.
// RULE_05 - PCM remote loop feeds transmitted PCM data back into received PCM.
// RULE_06 - Cross-connect 0 pairs PCM1-B1, PCM2-B2; 1 swaps them.
// RULE_07 - B2 code 00 layer2-layer1, 01 layer1-PCM, 10 PCM-layer2.
// RULE_08 - B1 code uses the same coding as B2.
// RULE_09 - Reset bit held 1ms or longer applies a full internal reset.
// RULE_10 - Reset bit never self-clears; software writes 0 to leave reset.
// RULE_11 - Register reads and writes are ignored while the reset bit is 1; the code still takes writes to the reset register.
// RULE_12 - Sleep enable resets to 0; at 1 sleep when line carries no signal.
// RULE_13 - Phase compensation code delays output by 0, 260, 520 or 1040 ns; the code gives 280 ns (7 cycles) for 260.
// RULE_14 - Source 0: indicator low when layer 1 active, high otherwise.
// RULE_15 - Source 1: indicator follows level bit, 0 high and 1 low.
// RULE_16 - Writing 1 to the wake-up bit leaves power-down.
// RULE_17 - Polarity 0 gives open-drain active-low interrupt; 1 active high.
// RULE_18 - Fixed-zero bits read 0 and ignore writes.
module misc_control_registers #(
    parameter int SOFT_RESET_HOLD_HOLD = misc_ctrl_pkg::SOFT_RESET_HOLD_HOLD_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [misc_ctrl_pkg::ADDR_BITS-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [misc_ctrl_pkg::ADDR_BITS-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [2:0] gpio_line_in,
    output logic [2:0] gpio_line_out,
    output logic [2:0] gpio_line_oe,
    output logic irq0_from_pin,
    input wire logic layer1_active,
    input wire logic line_no_signal,
    output logic sys_clock_run,
    output logic chip_reset_n,
    input wire logic tx_phase_in,
    output logic tx_phase_out,
    output logic activation_indicator_n,
    input wire logic irq_request,
    output logic irq_pin_out,
    output logic irq_pin_oe,
    output logic codec_on_pcm,
    input var misc_ctrl_pkg::b_octets_t [1:0] b_in,
    output misc_ctrl_pkg::b_octets_t [1:0] b_out
);
    logic [7:0] dir, io_data, sw_ctl, aux1, aux2, aux3, pin_mode;
    logic [4:0] sync_a, sync_b;
    logic [31:0] hold_cnt;
    logic soft_applied, int_rst_n, soft_reset_hold, wr_go, rd_go, wr_ok, we, wake_wr;
    logic [7:0] wr_idx, rd_idx, rd_val;
    logic rd_ok;
    logic [misc_ctrl_pkg::PHASE3_CYC-1:0] delay_line;
    misc_ctrl_pkg::pwr_state_t pwr;
    misc_ctrl_pkg::b_octets_t [1:0] rt_rx, rt_tx;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: only the second stage is read.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= {line_no_signal, layer1_active, gpio_line_in};
            sync_b <= sync_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave. One write and one read may be outstanding, answered one edge later.
    function automatic logic mapped(input logic [misc_ctrl_pkg::ADDR_BITS-1:0] a);
        mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0)
            && (a[9:2] >= misc_ctrl_pkg::IDX_DIR) && (a[9:2] <= misc_ctrl_pkg::IDX_STATUS);
    endfunction

    assign soft_reset_hold = aux1[misc_ctrl_pkg::AUX1_SOFT_RESET_HOLD];
    assign wr_go = awvalid && wvalid && !bvalid;
    assign awready = wr_go;
    assign wready = wr_go;
    assign rd_go = arvalid && !rvalid;
    assign arready = !rvalid;
    assign wr_idx = awaddr[9:2];
    assign rd_idx = araddr[9:2];
    assign wr_ok = mapped(awaddr);
    assign rd_ok = mapped(araddr);
    // The reset register alone stays writable in reset, or software could never leave it.
    // RULE_11 access inhibit
    assign we = wr_go && wr_ok && wstrb[0] && (!soft_reset_hold || wr_idx == misc_ctrl_pkg::IDX_AUX1);
    assign wake_wr = we && wr_idx == misc_ctrl_pkg::IDX_AUX2 && wdata[misc_ctrl_pkg::AUX2_SPU];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= misc_ctrl_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_ok ? misc_ctrl_pkg::RESP_OKAY : misc_ctrl_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_comb begin
        rd_val = 8'h00;
        unique case (rd_idx)
            misc_ctrl_pkg::IDX_DIR: rd_val = dir;
            // RULE_01 live pin levels
            misc_ctrl_pkg::IDX_IO: rd_val = {5'h00, sync_b[2:0]};
            misc_ctrl_pkg::IDX_SW: rd_val = sw_ctl;
            misc_ctrl_pkg::IDX_AUX1: rd_val = aux1;
            misc_ctrl_pkg::IDX_AUX2: rd_val = aux2;
            misc_ctrl_pkg::IDX_AUX3: rd_val = aux3;
            misc_ctrl_pkg::IDX_PINMODE: rd_val = pin_mode;
            misc_ctrl_pkg::IDX_STATUS: rd_val = {6'h00, pwr == misc_ctrl_pkg::pwr_asleep, sync_b[3]};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= misc_ctrl_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            // RULE_11 reads blanked
            rdata <= (rd_ok && !soft_reset_hold) ? {24'h00_0000, rd_val} : 32'h0000_0000;
            rresp <= rd_ok ? misc_ctrl_pkg::RESP_OKAY : misc_ctrl_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers. The masks keep fixed-zero bits at zero whatever is written.
    // RULE_18 masked writes
    always_ff @(posedge aclk) begin
        if (!int_rst_n) begin
            dir <= misc_ctrl_pkg::RST_DIR;
            io_data <= misc_ctrl_pkg::RST_IO;
            sw_ctl <= misc_ctrl_pkg::RST_SW;
            aux2 <= misc_ctrl_pkg::RST_AUX2;
            aux3 <= misc_ctrl_pkg::RST_AUX3;
            pin_mode <= misc_ctrl_pkg::RST_PINMODE;
        end else if (we) begin
            unique case (wr_idx)
                misc_ctrl_pkg::IDX_DIR: dir <= wdata[7:0] & misc_ctrl_pkg::MASK_DIR;
                misc_ctrl_pkg::IDX_IO: io_data <= wdata[7:0] & misc_ctrl_pkg::MASK_IO;
                misc_ctrl_pkg::IDX_SW: sw_ctl <= wdata[7:0] & misc_ctrl_pkg::MASK_SW;
                misc_ctrl_pkg::IDX_AUX2: aux2 <= wdata[7:0] & misc_ctrl_pkg::MASK_AUX2;
                misc_ctrl_pkg::IDX_AUX3: aux3 <= wdata[7:0] & misc_ctrl_pkg::MASK_AUX3;
                misc_ctrl_pkg::IDX_PINMODE: pin_mode <= wdata[7:0] & misc_ctrl_pkg::MASK_PINMODE;
                default: ;
            endcase
        end
    end

    // The reset bit survives its own internal reset; only software or the pin clears it.
    // RULE_10 no self clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux1 <= misc_ctrl_pkg::RST_AUX1;
        end else if (we && wr_idx == misc_ctrl_pkg::IDX_AUX1) begin
            aux1 <= wdata[7:0] & misc_ctrl_pkg::MASK_AUX1;
        end else if (!int_rst_n) begin
            aux1 <= aux1 & (8'h01 << misc_ctrl_pkg::AUX1_SOFT_RESET_HOLD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software reset: applied once the bit has stood for the hold time.
    // RULE_09 hold then reset
    always_ff @(posedge aclk) begin
        if (!aresetn || !soft_reset_hold) begin
            hold_cnt <= 32'h0000_0000;
            soft_applied <= 1'b0;
        end else begin
            if (hold_cnt < 32'(SOFT_RESET_HOLD_HOLD)) begin
                hold_cnt <= hold_cnt + 32'h0000_0001;
            end
            soft_applied <= hold_cnt >= 32'(SOFT_RESET_HOLD_HOLD - 1);
        end
    end
    assign int_rst_n = aresetn && !soft_applied;
    assign chip_reset_n = int_rst_n;

    ////////////////////////////////////////////////////////////////////////////
    // General-purpose lines; the shared line yields to the interrupt input mode.
    // RULE_02 drive gating
    assign gpio_line_out = io_data[2:0];
    assign gpio_line_oe = dir[2:0] & {~pin_mode[misc_ctrl_pkg::PIN_IRQ0], 2'h3};
    // RULE_03 shared pin mode
    assign irq0_from_pin = pin_mode[misc_ctrl_pkg::PIN_IRQ0] && sync_b[misc_ctrl_pkg::SHARED_LINE];

    ////////////////////////////////////////////////////////////////////////////
    // B channel switching.
    // RULE_04 codec bus
    assign codec_on_pcm = sw_ctl[misc_ctrl_pkg::SW_CODEC];

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam int SEL_LSB = (ch == 0) ? misc_ctrl_pkg::SW_B1 : misc_ctrl_pkg::SW_B2;
        logic [1:0] port;
        // RULE_06 cross connect
        assign port = sw_ctl[misc_ctrl_pkg::SW_PXC] ? 2'(1 - ch) : 2'(ch);
        assign rt_rx[ch].l1 = b_in[ch].l1;
        assign rt_rx[ch].l2 = b_in[ch].l2;
        // RULE_05 remote loop
        assign rt_rx[ch].pcm = sw_ctl[misc_ctrl_pkg::SW_LOOP] ? b_out[port[0]].pcm
                                                               : b_in[port[0]].pcm;
        assign b_out[ch] = '{l1: rt_tx[ch].l1, l2: rt_tx[ch].l2, pcm: rt_tx[port[0]].pcm};
        // RULE_07 RULE_08 route codes
        b_channel_router u_router (
            .aclk(aclk),
            .rst_n(int_rst_n),
            .sel(sw_ctl[SEL_LSB +: 2]),
            .rx(rt_rx[ch]),
            .tx(rt_tx[ch])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Automatic power-down. A returning line signal also wakes the clock.
    // RULE_12 RULE_16 sleep and wake
    always_ff @(posedge aclk) begin
        if (!int_rst_n) begin
            pwr <= misc_ctrl_pkg::pwr_awake;
        end else begin
            unique case (pwr)
                misc_ctrl_pkg::pwr_awake: begin
                    if (aux1[misc_ctrl_pkg::AUX1_PD] && sync_b[4] && !wake_wr) begin
                        pwr <= misc_ctrl_pkg::pwr_asleep;
                    end
                end
                misc_ctrl_pkg::pwr_asleep: begin
                    if (wake_wr || !aux1[misc_ctrl_pkg::AUX1_PD] || !sync_b[4]) begin
                        pwr <= misc_ctrl_pkg::pwr_awake;
                    end
                end
            endcase
        end
    end
    assign sys_clock_run = (pwr == misc_ctrl_pkg::pwr_awake);

    ////////////////////////////////////////////////////////////////////////////
    // Output phase compensation as a tapped delay line, rounded up to whole cycles.
    // RULE_13 delay taps
    always_ff @(posedge aclk) begin
        if (!int_rst_n) begin
            delay_line <= '0;
        end else begin
            delay_line <= {delay_line[misc_ctrl_pkg::PHASE3_CYC-2:0], tx_phase_in};
        end
    end

    always_comb begin
        unique case (aux1[misc_ctrl_pkg::AUX1_OPS +: 2])
            2'h0: tx_phase_out = tx_phase_in;
            2'h1: tx_phase_out = delay_line[misc_ctrl_pkg::PHASE1_CYC-1];
            2'h2: tx_phase_out = delay_line[misc_ctrl_pkg::PHASE2_CYC-1];
            2'h3: tx_phase_out = delay_line[misc_ctrl_pkg::PHASE3_CYC-1];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Activation indicator and interrupt pin.
    // RULE_14 RULE_15 indicator
    always_ff @(posedge aclk) begin
        if (!int_rst_n) begin
            activation_indicator_n <= 1'b1;
        end else if (aux2[misc_ctrl_pkg::AUX2_SRC]) begin
            activation_indicator_n <= ~aux2[misc_ctrl_pkg::AUX2_LC];
        end else begin
            activation_indicator_n <= ~sync_b[3];
        end
    end

    // Open-drain mode only ever pulls low; the board supplies the high level.
    // RULE_17 polarity
    assign irq_pin_out = aux3[misc_ctrl_pkg::AUX3_POL] && irq_request;
    assign irq_pin_oe = aux3[misc_ctrl_pkg::AUX3_POL] || irq_request;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_io_read;
        rd_go && rd_ok && !soft_reset_hold && rd_idx == misc_ctrl_pkg::IDX_IO;
    endsequence
    property p_io_read;
        s_io_read |=> rdata[2:0] == $past(sync_b[2:0]) && rdata[31:3] == 29'h0;
    endproperty
    a_io_read: assert property (p_io_read) else $error("I/O read not pin level"); // RULE_01

    property p_drive_gate;
        !dir[0] |-> !gpio_line_oe[0] && !(pin_mode[0] && gpio_line_oe[2]);
    endproperty
    a_drive_gate: assert property (p_drive_gate) else $error("line driven while input"); // RULE_02

    property p_codec;
        we && wr_idx == misc_ctrl_pkg::IDX_SW |=> codec_on_pcm == $past(wdata[6]);
    endproperty
    a_codec: assert property (p_codec) else $error("codec bus select not applied"); // RULE_04

    property p_loop;
        sw_ctl[misc_ctrl_pkg::SW_LOOP] && !sw_ctl[misc_ctrl_pkg::SW_PXC] |-> rt_rx[0].pcm == b_out[0].pcm;
    endproperty
    a_loop: assert property (p_loop) else $error("remote loop not fed back"); // RULE_05

    property p_cross;
        sw_ctl[misc_ctrl_pkg::SW_PXC] && !sw_ctl[misc_ctrl_pkg::SW_LOOP] |-> rt_rx[0].pcm == b_in[1].pcm;
    endproperty
    a_cross: assert property (p_cross) else $error("cross-connect port wrong"); // RULE_06

    sequence s_soft_reset_hold_rise;
        soft_reset_hold && !$past(soft_reset_hold);
    endsequence
    property p_soft_reset_hold;
        s_soft_reset_hold_rise |-> chip_reset_n [*2];
    endproperty
    a_soft_reset_hold: assert property (p_soft_reset_hold) else $error("soft reset applied too early"); // RULE_09

    property p_soft_reset_hold_apply;
        soft_reset_hold && hold_cnt == 32'(SOFT_RESET_HOLD_HOLD - 1) |=> !chip_reset_n;
    endproperty
    a_soft_reset_hold_apply: assert property (p_soft_reset_hold_apply) else $error("soft reset not applied"); // RULE_09

    property p_inhibit;
        chip_reset_n && soft_reset_hold && wr_go && wr_idx == misc_ctrl_pkg::IDX_SW |=> $stable(sw_ctl);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("write taken in soft reset"); // RULE_11

    property p_sleep;
        int_rst_n && sys_clock_run && aux1[2] && sync_b[4] && !wake_wr |=> !sys_clock_run;
    endproperty
    a_sleep: assert property (p_sleep) else $error("power-down not entered"); // RULE_12

    property p_phase1;
        (aux1[1:0] == 2'h1) [*8] |-> tx_phase_out == $past(tx_phase_in, 7);
    endproperty
    a_phase1: assert property (p_phase1) else $error("260 ns delay wrong"); // RULE_13

    property p_ind_auto;
        int_rst_n && !aux2[6] && sync_b[3] |=> !activation_indicator_n;
    endproperty
    a_ind_auto: assert property (p_ind_auto) else $error("indicator not low when active"); // RULE_14

    property p_ind_sw;
        int_rst_n && aux2[6] && !aux2[5] |=> activation_indicator_n;
    endproperty
    a_ind_sw: assert property (p_ind_sw) else $error("indicator level bit ignored"); // RULE_15

    property p_wake;
        wake_wr && int_rst_n |=> sys_clock_run;
    endproperty
    a_wake: assert property (p_wake) else $error("wake-up write ignored"); // RULE_16

    property p_irq_od;
        !aux3[6] |-> !irq_pin_out && (irq_pin_oe == irq_request);
    endproperty
    a_irq_od: assert property (p_irq_od) else $error("open-drain interrupt drive wrong"); // RULE_17

    property p_fixed_zero;
        rd_go && rd_idx == misc_ctrl_pkg::IDX_SW |=> !rdata[7];
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bit reads one"); // RULE_18
endmodule
`default_nettype wire

// >>> gpio_pin_model.sv
// Pin-side model of the three general-purpose I/O lines.
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_model (
    input wire logic [2:0] drive,
    input wire logic [2:0] drive_en,
    input wire logic [2:0] far_level,
    output logic [2:0] pin
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin[i] = drive_en[i] ? drive[i] : far_level[i];
        end
    end
endmodule
`default_nettype wire

// >>> misc_control_registers_bench.sv
// Self-checking bench for the miscellaneous control registers.
`timescale 1ns/100ps
`default_nettype none
module misc_control_registers_bench;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, layer1_active = 1'b0, line_no_signal = 1'b0;
    logic irq_request = 1'b0, ok, seen_run = 1'b0, tx_phase_in = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0] bresp, rresp, rr, rb;
    logic awready, wready, bvalid, arready, rvalid, irq0_from_pin, sys_clock_run, chip_reset_n;
    logic tx_phase_out, activation_indicator_n, irq_pin_out, irq_pin_oe, codec_on_pcm;
    logic [2:0] gpio_line_out, gpio_line_oe, gpio_line_in, far = 3'h0;
    misc_ctrl_pkg::b_octets_t [1:0] b_in = {24'hD4E596, 24'hA1B2C3};
    misc_ctrl_pkg::b_octets_t [1:0] b_out;
    int failures = 0;
    int tests_run = 0;

    misc_control_registers #(.SOFT_RESET_HOLD_HOLD(20)) dut (.aclk, .aresetn, .awaddr, .awprot(3'h0),
        .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .gpio_line_in, .gpio_line_out, .gpio_line_oe, .irq0_from_pin, .layer1_active,
        .line_no_signal, .sys_clock_run, .chip_reset_n, .tx_phase_in, .tx_phase_out,
        .activation_indicator_n, .irq_request, .irq_pin_out, .irq_pin_oe, .codec_on_pcm,
        .b_in, .b_out);
    gpio_pin_model pins (.drive(gpio_line_out), .drive_en(gpio_line_oe), .far_level(far),
        .pin(gpio_line_in));

    initial begin
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (sys_clock_run === 1'b1) seen_run <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function logic [11:0] ad(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction
    function misc_ctrl_pkg::b_octets_t xr(input misc_ctrl_pkg::b_octets_t i, input int c);
        xr = {24'hFFFFFF};
        case (c)
            0: begin xr.l1 = i.l2; xr.l2 = i.l1; end
            1: begin xr.l1 = i.pcm; xr.pcm = i.l1; end
            default: begin xr.pcm = i.l2; xr.l2 = i.pcm; end
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Inputs are sampled 1 ns after an edge so combinational ready has settled.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin #1 ok = awready; @(posedge aclk); end while (ok !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        do begin #1 ok = bvalid; rb = bresp; @(posedge aclk); end while (ok !== 1'b1);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin #1 ok = arready; @(posedge aclk); end while (ok !== 1'b1);
        arvalid <= 1'b0;
        do begin #1 ok = rvalid; rv = rdata; rr = rresp; @(posedge aclk); end while (ok !== 1'b1);
        rready <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(ad(misc_ctrl_pkg::IDX_AUX2)); chk(rv, 32'h40);
        rd(ad(misc_ctrl_pkg::IDX_AUX1)); chk(rv, 32'h00);
        wr(12'h200, 8'h01); rd(12'h200); chk({rb, rr}, {2{misc_ctrl_pkg::RESP_SLVERR}});
        wr(ad(misc_ctrl_pkg::IDX_SW), 8'hFF); rd(ad(misc_ctrl_pkg::IDX_SW)); chk(rv, 32'h7F);
        chk(codec_on_pcm, 1'b1);
        wr(ad(misc_ctrl_pkg::IDX_AUX3), 8'hFF); rd(ad(misc_ctrl_pkg::IDX_AUX3)); chk(rv, 32'h40);
        $display("test regs finished");
    endtask
    task automatic t_gpio();
        far <= 3'b101;
        wr(ad(misc_ctrl_pkg::IDX_DIR), 8'h03); wr(ad(misc_ctrl_pkg::IDX_IO), 8'h02);
        repeat (3) @(posedge aclk);
        rd(ad(misc_ctrl_pkg::IDX_IO)); chk(rv, 32'h06);
        chk(gpio_line_oe, 3'b011);
        wr(ad(misc_ctrl_pkg::IDX_PINMODE), 8'h01); chk(irq0_from_pin, 1'b1);
        $display("test gpio finished");
    endtask
    task automatic t_route();
        for (int ch = 0; ch < 2; ch++) begin
            for (int c = 0; c < 3; c++) begin
                wr(ad(misc_ctrl_pkg::IDX_SW), 8'(c << (2 * ch))); repeat (3) @(posedge aclk);
                chk(b_out[ch], xr(b_in[ch], c));
            end
        end
        chk(codec_on_pcm, 1'b0);
        wr(ad(misc_ctrl_pkg::IDX_SW), 8'h21); repeat (4) @(posedge aclk);
        chk(b_out[0].l1, b_in[0].l1);
        wr(ad(misc_ctrl_pkg::IDX_SW), 8'h11); repeat (3) @(posedge aclk);
        chk(b_out[1].pcm, b_in[0].l1);
        $display("test route finished");
    endtask
    task automatic t_pins();
        wr(ad(misc_ctrl_pkg::IDX_AUX2), 8'h60); repeat (2) @(posedge aclk);
        chk(activation_indicator_n, 1'b0);
        wr(ad(misc_ctrl_pkg::IDX_AUX2), 8'h00); layer1_active <= 1'b1; repeat (4) @(posedge aclk);
        chk(activation_indicator_n, 1'b0);
        layer1_active <= 1'b0; repeat (4) @(posedge aclk);
        chk(activation_indicator_n, 1'b1);
        irq_request <= 1'b1; repeat (2) @(posedge aclk);
        chk({irq_pin_out, irq_pin_oe}, 2'b11);
        wr(ad(misc_ctrl_pkg::IDX_AUX3), 8'h00); repeat (2) @(posedge aclk);
        chk({irq_pin_out, irq_pin_oe}, 2'b01);
        irq_request <= 1'b0;
        $display("test pins finished");
    endtask
    task automatic t_phase();
        wr(ad(misc_ctrl_pkg::IDX_AUX1), 8'h01); tx_phase_in <= 1'b1; repeat (6) @(posedge aclk);
        #1 chk(tx_phase_out, 1'b0);
        @(posedge aclk); #1 chk(tx_phase_out, 1'b1);
        @(posedge aclk); tx_phase_in <= 1'b0;
        $display("test phase finished");
    endtask
    task automatic t_power();
        wr(ad(misc_ctrl_pkg::IDX_AUX1), 8'h04); line_no_signal <= 1'b1; repeat (5) @(posedge aclk);
        chk(sys_clock_run, 1'b0);
        seen_run <= 1'b0;
        wr(ad(misc_ctrl_pkg::IDX_AUX2), 8'h08); repeat (2) @(posedge aclk);
        chk(seen_run, 1'b1);
        line_no_signal <= 1'b0;
        $display("test power finished");
    endtask
    task automatic t_soft_reset_hold();
        wr(ad(misc_ctrl_pkg::IDX_AUX1), 8'h20); wr(ad(misc_ctrl_pkg::IDX_SW), 8'h40);
        rd(ad(misc_ctrl_pkg::IDX_SW)); chk(rv | rr, 32'h0);
        repeat (30) @(posedge aclk);
        chk(chip_reset_n, 1'b0);
        wr(ad(misc_ctrl_pkg::IDX_AUX1), 8'h00); repeat (2) @(posedge aclk);
        chk(chip_reset_n, 1'b1);
        rd(ad(misc_ctrl_pkg::IDX_SW)); chk(rv, 32'h00);
        $display("test soft reset finished");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs(); t_gpio(); t_route(); t_pins(); t_phase(); t_power(); t_soft_reset_hold();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
